// file: charger_setpoint_registers.sv
// Boost current, boost voltage and system floor setpoint registers
`timescale 1ns/10ps
`default_nettype none
module charger_setpoint_registers
  import setpoint_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  reg_reset_i,
  input  wire logic                  watchdog_expire_i,
  input  wire logic [ADDR_W-1:0]     addr_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [7:0]            rdata_o,
  output logic      [CUR_W-1:0]      boost_current_code_o,
  output logic      [VOLT_W-1:0]     boost_voltage_code_o,
  output logic      [FLOOR_W-1:0]    system_floor_code_o,
  output logic      [CUR_MA_W-1:0]   boost_current_ma_o,
  output logic      [VOLT_MV_W-1:0]  boost_voltage_mv_o,
  output logic      [FLOOR_MV_W-1:0] system_floor_mv_o
);

  if (ADDR_W < 4) begin : g_bad_addr_w
    $error("charger_setpoint_registers: ADDR_W too small for the map");
  end

  typedef struct packed {
    logic [CUR_W-1:0]                cur_code;
    logic [VOLT_W-1:0]               volt_code;
    logic [FLOOR_W-1:0]              floor_code;
    logic [NUM_WORDS-1:0][7:0]       pend_lo;
    logic [NUM_WORDS-1:0]            pend_v;
    logic [7:0]                      rdata;
    logic [CUR_MA_W-1:0]             cur_ma;
    logic [VOLT_MV_W-1:0]            volt_mv;
    logic [FLOOR_MV_W-1:0]           floor_mv;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  logic [NUM_WORDS-1:0][15:0] word_img;
  logic [NUM_WORDS-1:0][15:0] word_mask;
  logic [NUM_WORDS-1:0][7:0]  lo_addr;
  logic [NUM_WORDS-1:0]       hit_lo;
  logic [NUM_WORDS-1:0]       hit_hi;
  logic [NUM_WORDS-1:0][15:0] cand_word;
  logic [CUR_W-1:0]           cur_raw;
  logic [VOLT_W-1:0]          volt_raw;
  logic [FLOOR_W-1:0]         floor_raw;
  logic [CUR_W-1:0]           cur_clamped;
  logic [VOLT_W-1:0]          volt_clamped;
  logic [FLOOR_W-1:0]         floor_clamped;

  // Word images rebuilt from the codes; reserved positions are hard zero
  always_comb begin
    word_img[CUR_IDX]   = {4'h0, state_r.cur_code, 4'h0};
    word_img[VOLT_IDX]  = {3'h0, state_r.volt_code, 6'h00};
    word_img[FLOOR_IDX] = {4'h0, state_r.floor_code, 6'h00};
    word_mask[CUR_IDX]   = CUR_MASK;
    word_mask[VOLT_IDX]  = VOLT_MASK;
    word_mask[FLOOR_IDX] = FLOOR_MASK;
    lo_addr[CUR_IDX]     = CUR_LO_ADDR;
    lo_addr[VOLT_IDX]    = VOLT_LO_ADDR;
    lo_addr[FLOOR_IDX]   = FLOOR_LO_ADDR;
  end

  // Per-word decode and candidate word for a high-byte commit
  for (genvar k = 0; k < NUM_WORDS; k++) begin : g_word
    assign hit_lo[k] = (addr_i == ADDR_W'(lo_addr[k]));
    assign hit_hi[k] = (addr_i == ADDR_W'(lo_addr[k] | 8'h01));
    assign cand_word[k] = {wdata_i, state_r.pend_v[k] ? state_r.pend_lo[k] : word_img[k][7:0]}
                          & word_mask[k];
  end

  assign cur_raw   = cand_word[CUR_IDX][CUR_LSB +: CUR_W];
  assign volt_raw  = cand_word[VOLT_IDX][VOLT_LSB +: VOLT_W];
  assign floor_raw = cand_word[FLOOR_IDX][FLOOR_LSB +: FLOOR_W];

  code_clamp #(.W(CUR_W), .LO(CUR_MIN), .HI(CUR_MAX)) u_cur_clamp (
    .raw_i  (cur_raw),
    .code_o (cur_clamped)
  );

  code_clamp #(.W(VOLT_W), .LO(VOLT_MIN), .HI(VOLT_MAX)) u_volt_clamp (
    .raw_i  (volt_raw),
    .code_o (volt_clamped)
  );

  code_clamp #(.W(FLOOR_W), .LO(FLOOR_MIN), .HI(FLOOR_MAX)) u_floor_clamp (
    .raw_i  (floor_raw),
    .code_o (floor_clamped)
  );

  always_comb begin
    state_nxt = state_r;

    // Read answers next cycle with the value held before any same-cycle write
    if (rd_i) begin
      state_nxt.rdata = 8'h00;
      for (int k = 0; k < NUM_WORDS; k++) begin
        if (hit_lo[k]) begin
          state_nxt.rdata = word_img[k][7:0];
        end else if (hit_hi[k]) begin
          state_nxt.rdata = word_img[k][15:8];
        end
      end
    end

    // Low byte is staged so a straddling field is clamped as a whole
    if (wr_i) begin
      for (int k = 0; k < NUM_WORDS; k++) begin
        if (hit_lo[k]) begin
          state_nxt.pend_lo[k] = wdata_i & word_mask[k][7:0];
          state_nxt.pend_v[k]  = 1'b1;
        end else if (hit_hi[k]) begin
          state_nxt.pend_v[k]  = 1'b0;
        end
      end
      if (hit_hi[CUR_IDX]) begin
        state_nxt.cur_code = cur_clamped;
      end
      if (hit_hi[VOLT_IDX]) begin
        state_nxt.volt_code = volt_clamped;
      end
      if (hit_hi[FLOOR_IDX]) begin
        state_nxt.floor_code = floor_clamped;
      end
    end

    // Resets beat a write in the same cycle
    if (watchdog_expire_i) begin
      state_nxt.cur_code        = CUR_CODE_RST;
      state_nxt.pend_v[CUR_IDX] = 1'b0;
    end
    if (reg_reset_i) begin
      state_nxt.cur_code   = CUR_CODE_RST;
      state_nxt.volt_code  = VOLT_CODE_RST;
      state_nxt.floor_code = FLOOR_CODE_RST;
      state_nxt.pend_v     = '0;
    end

    state_nxt.cur_ma   = CUR_MA_W'(state_nxt.cur_code * CUR_STEP_MA);
    state_nxt.volt_mv  = VOLT_MV_W'(state_nxt.volt_code * VOLT_STEP_MV);
    state_nxt.floor_mv = FLOOR_MV_W'(state_nxt.floor_code * FLOOR_STEP_MV);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r.cur_code   <= CUR_WORD_RST[CUR_LSB +: CUR_W];
      state_r.volt_code  <= VOLT_WORD_RST[VOLT_LSB +: VOLT_W];
      state_r.floor_code <= FLOOR_WORD_RST[FLOOR_LSB +: FLOOR_W];
      state_r.pend_lo    <= '0;
      state_r.pend_v     <= '0;
      state_r.rdata      <= 8'h00;
      state_r.cur_ma     <= CUR_MA_W'(CUR_CODE_RST * CUR_STEP_MA);
      state_r.volt_mv    <= VOLT_MV_W'(VOLT_CODE_RST * VOLT_STEP_MV);
      state_r.floor_mv   <= FLOOR_MV_W'(FLOOR_CODE_RST * FLOOR_STEP_MV);
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rdata_o              = state_r.rdata;
  assign boost_current_code_o = state_r.cur_code;
  assign boost_voltage_code_o = state_r.volt_code;
  assign system_floor_code_o  = state_r.floor_code;
  assign boost_current_ma_o   = state_r.cur_ma;
  assign boost_voltage_mv_o   = state_r.volt_mv;
  assign system_floor_mv_o    = state_r.floor_mv;

endmodule : charger_setpoint_registers
`default_nettype wire

// file: setpoint_pkg.sv
// Constants and types shared by the charger setpoint register bank
// Notes on behaviour
// - Current limit code sits in word 0xA bits 11:4
// - Current code 20 mA steps, clamped 5h..A0h
// - Current word 0x0320; reset and watchdog give 32h
// - Boost voltage code sits in word 0xC bits 12:6
// - Voltage code 80 mV steps, clamped 30h..78h
// - Voltage word 0x0FC0, code 3Fh, register reset only
// - System floor code sits in word 0xE bits 11:6
// - Floor word 0x0B00, code 2Ch, register reset restores it
// - Words little-endian: low byte at lower address
`default_nettype none
package setpoint_pkg;

  localparam int NUM_WORDS = 3;

  // Byte addresses of the low byte of each word; the high byte follows
  localparam logic [7:0] CUR_LO_ADDR   = 8'h0a;
  localparam logic [7:0] VOLT_LO_ADDR  = 8'h0c;
  localparam logic [7:0] FLOOR_LO_ADDR = 8'h0e;

  // Word indices into the per-word arrays
  localparam logic [1:0] CUR_IDX   = 2'h0;
  localparam logic [1:0] VOLT_IDX  = 2'h1;
  localparam logic [1:0] FLOOR_IDX = 2'h2;

  // Field positions and widths
  localparam int CUR_LSB   = 4;
  localparam int CUR_W     = 8;
  localparam int VOLT_LSB  = 6;
  localparam int VOLT_W    = 7;
  localparam int FLOOR_LSB = 6;
  localparam int FLOOR_W   = 6;

  // Writable-bit masks per word; everything else is reserved
  localparam logic [15:0] CUR_MASK   = 16'h0ff0;
  localparam logic [15:0] VOLT_MASK  = 16'h1fc0;
  localparam logic [15:0] FLOOR_MASK = 16'h0fc0;

  // Reset values
  localparam logic [15:0]        CUR_WORD_RST   = 16'h0320;
  localparam logic [15:0]        VOLT_WORD_RST  = 16'h0fc0;
  localparam logic [15:0]        FLOOR_WORD_RST = 16'h0b00;
  localparam logic [CUR_W-1:0]   CUR_CODE_RST   = 8'h32;
  localparam logic [VOLT_W-1:0]  VOLT_CODE_RST  = 7'h3f;
  localparam logic [FLOOR_W-1:0] FLOOR_CODE_RST = 6'h2c;

  // Clamp limits
  localparam logic [CUR_W-1:0]   CUR_MIN   = 8'h05;
  localparam logic [CUR_W-1:0]   CUR_MAX   = 8'ha0;
  localparam logic [VOLT_W-1:0]  VOLT_MIN  = 7'h30;
  localparam logic [VOLT_W-1:0]  VOLT_MAX  = 7'h78;
  localparam logic [FLOOR_W-1:0] FLOOR_MIN = 6'h20;
  localparam logic [FLOOR_W-1:0] FLOOR_MAX = 6'h30;

  // Step sizes, in mA and mV; code times step gives the setpoint
  localparam int CUR_STEP_MA   = 20;
  localparam int VOLT_STEP_MV  = 80;
  localparam int FLOOR_STEP_MV = 80;
  localparam int CUR_MA_W      = 12;
  localparam int VOLT_MV_W     = 14;
  localparam int FLOOR_MV_W    = 12;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_LOW,
    SEL_HIGH
  } byte_sel_type;

endpackage : setpoint_pkg
`default_nettype wire

// file: code_clamp.sv
// Saturating limiter for one setpoint code
`timescale 1ns/10ps
`default_nettype none
module code_clamp #(
  parameter int           W  = 8,
  parameter logic [W-1:0] LO = '0,
  parameter logic [W-1:0] HI = '1
) (
  input  wire logic [W-1:0] raw_i,
  output logic      [W-1:0] code_o
);

  if (W < 1 || LO > HI) begin : g_bad_param
    $error("code_clamp: bad width or limits");
  end

  always_comb begin
    if (raw_i < LO) begin
      code_o = LO;
    end else if (raw_i > HI) begin
      code_o = HI;
    end else begin
      code_o = raw_i;
    end
  end

endmodule : code_clamp
`default_nettype wire

// file: charger_setpoint_registers_props.sv
// Checker for the setpoint register bank ports
`timescale 1ns/10ps
`default_nettype none
module charger_setpoint_registers_props
  import setpoint_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  reg_reset_i,
  input wire logic                  watchdog_expire_i,
  input wire logic [ADDR_W-1:0]     addr_i,
  input wire logic                  wr_i,
  input wire logic                  rd_i,
  input wire logic [7:0]            rdata_o,
  input wire logic [CUR_W-1:0]      boost_current_code_o,
  input wire logic [VOLT_W-1:0]     boost_voltage_code_o,
  input wire logic [FLOOR_W-1:0]    system_floor_code_o,
  input wire logic [CUR_MA_W-1:0]   boost_current_ma_o,
  input wire logic [VOLT_MV_W-1:0]  boost_voltage_mv_o,
  input wire logic [FLOOR_MV_W-1:0] system_floor_mv_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_cur_ma; boost_current_ma_o == boost_current_code_o * 12'h014; endproperty
  a_cur_ma: assert property (p_cur_ma) else $error("current mA wrong");
  property p_volt_mv; boost_voltage_mv_o == boost_voltage_code_o * 14'h0050; endproperty
  a_volt_mv: assert property (p_volt_mv) else $error("voltage mV wrong");
  property p_floor_mv; system_floor_mv_o == system_floor_code_o * 12'h050; endproperty
  a_floor_mv: assert property (p_floor_mv) else $error("floor mV wrong");
  property p_cur_rng; boost_current_code_o inside {[8'h05:8'ha0]}; endproperty
  a_cur_rng: assert property (p_cur_rng) else $error("current code unclamped");
  property p_volt_rng; boost_voltage_code_o inside {[7'h30:7'h78]}; endproperty
  a_volt_rng: assert property (p_volt_rng) else $error("voltage code unclamped");
  property p_floor_rng; system_floor_code_o inside {[6'h20:6'h30]}; endproperty
  a_floor_rng: assert property (p_floor_rng) else $error("floor code unclamped");
  property p_soft; reg_reset_i |=> boost_current_code_o == 8'h32 && boost_voltage_code_o == 7'h3f
    && system_floor_code_o == 6'h2c; endproperty
  a_soft: assert property (p_soft) else $error("register reset missed");
  property p_wdog; watchdog_expire_i |=> boost_current_code_o == 8'h32; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog reset missed");
  // A commit lands at the edge that takes the write, so only a same-cycle write or register reset is excluded
  property p_wdog_v; watchdog_expire_i && !reg_reset_i && !wr_i |=>
    $stable(boost_voltage_code_o); endproperty
  a_wdog_v: assert property (p_wdog_v) else $error("watchdog hit voltage");
  property p_low; wr_i && addr_i == CUR_LO_ADDR && !reg_reset_i && !watchdog_expire_i
    |=> $stable(boost_current_code_o); endproperty
  a_low: assert property (p_low) else $error("low byte committed alone");
  property p_unmap; rd_i && (addr_i < 8'h0a || addr_i > 8'h0f) |=> rdata_o == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule : charger_setpoint_registers_props
bind charger_setpoint_registers charger_setpoint_registers_props #(.ADDR_W(ADDR_W)) props (.clk_i, .rst_i,
  .reg_reset_i, .watchdog_expire_i, .addr_i, .wr_i, .rd_i, .rdata_o, .boost_current_code_o,
  .boost_voltage_code_o, .system_floor_code_o, .boost_current_ma_o, .boost_voltage_mv_o, .system_floor_mv_o);
`default_nettype wire

// file: charger_setpoint_registers_bench.sv
// Testbench for the setpoint register bank
`timescale 1ns/10ps
`default_nettype none
module charger_setpoint_registers_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        reg_reset_i = 1'b0;
  logic        watchdog_expire_i = 1'b0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic [7:0]  rdata_o;
  logic [7:0]  cur_code;
  logic [6:0]  volt_code;
  logic [5:0]  floor_code;
  logic [11:0] cur_ma;
  logic [13:0] volt_mv;
  logic [11:0] floor_mv;
  int          fails = 0;
  int          tests_run = 0;
  always #25 clk_i = ~clk_i;
  charger_setpoint_registers DUT (.clk_i(clk_i), .rst_i(rst_i), .reg_reset_i(reg_reset_i),
    .watchdog_expire_i(watchdog_expire_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .boost_current_code_o(cur_code), .boost_voltage_code_o(volt_code),
    .system_floor_code_o(floor_code), .boost_current_ma_o(cur_ma), .boost_voltage_mv_o(volt_mv),
    .system_floor_mv_o(floor_mv));
  task ck(input logic [15:0] a, input logic [15:0] e);
    tests_run++;
    if (a !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, a, e);
    end
  endtask : ck
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  // Reads both bytes of a word, low address first
  task rw(input logic [7:0] a, input logic [15:0] e);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a + i[7:0];
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 ck({8'h00, rdata_o}, {8'h00, e[i*8 +: 8]});
    end
  endtask : rw
  task pulse(input logic wdog);
    @(posedge clk_i);
    watchdog_expire_i <= wdog;
    reg_reset_i <= ~wdog;
    @(posedge clk_i);
    watchdog_expire_i <= 1'b0;
    reg_reset_i <= 1'b0;
  endtask : pulse
  task conclude;
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  // Whole sequence needs about 8 us; the margin covers a stuck design
  initial begin
    #50us;
    fails++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rw(8'h0a, 16'h0320);
    rw(8'h0c, 16'h0fc0);
    rw(8'h0e, 16'h0b00);
    ck({9'h000, volt_code}, 16'h003f);
    ck({10'h000, floor_code}, 16'h002c);
    ck({4'h0, cur_ma}, 16'h03e8);
    ck({2'h0, volt_mv}, 16'h13b0);
    ck({4'h0, floor_mv}, 16'h0dc0);
    wr(8'h0a, 8'hf0);
    ck({8'h00, cur_code}, 16'h0032);
    wr(8'h0b, 8'h0f);
    rw(8'h0a, 16'h0a00);
    ck({4'h0, cur_ma}, 16'h0c80);
    wr(8'h0a, 8'h7f);
    wr(8'h0b, 8'hf1);
    rw(8'h0a, 16'h0170);
    wr(8'h0a, 8'h30);
    wr(8'h0b, 8'h00);
    rw(8'h0a, 16'h0050);
    wr(8'h0c, 8'hff);
    wr(8'h0d, 8'hff);
    rw(8'h0c, 16'h1e00);
    wr(8'h0c, 8'h40);
    wr(8'h0d, 8'h10);
    rw(8'h0c, 16'h1040);
    ck({2'h0, volt_mv}, 16'h1450);
    wr(8'h0c, 8'h00);
    wr(8'h0d, 8'h00);
    rw(8'h0c, 16'h0c00);
    wr(8'h0e, 8'hc0);
    wr(8'h0f, 8'h0f);
    rw(8'h0e, 16'h0c00);
    wr(8'h0e, 8'h40);
    wr(8'h0f, 8'h0a);
    rw(8'h0e, 16'h0a40);
    ck({4'h0, floor_mv}, 16'h0cd0);
    wr(8'h0e, 8'h00);
    wr(8'h0f, 8'h00);
    rw(8'h0e, 16'h0800);
    wr(8'h09, 8'hff);
    wr(8'h10, 8'hff);
    rw(8'h10, 16'h0000);
    rw(8'h0e, 16'h0800);
    rw(8'h0a, 16'h0050);
    pulse(1'b1);
    rw(8'h0a, 16'h0320);
    rw(8'h0c, 16'h0c00);
    // Watchdog must drop a staged low byte as well
    wr(8'h0a, 8'hf0);
    pulse(1'b1);
    wr(8'h0b, 8'h00);
    rw(8'h0a, 16'h0050);
    wr(8'h0b, 8'h01);
    pulse(1'b0);
    rw(8'h0a, 16'h0320);
    rw(8'h0c, 16'h0fc0);
    rw(8'h0e, 16'h0b00);
    // Register reset must drop a staged low byte as well
    wr(8'h0c, 8'h00);
    pulse(1'b0);
    wr(8'h0d, 8'h0f);
    rw(8'h0c, 16'h0fc0);
    conclude();
  end
endmodule : charger_setpoint_registers_bench
`default_nettype wire
